// *** aes_pkg.sv ***
// ****************************************
// Constants and carriers
// ****************************************
package aes_pkg;

   localparam int AXES_DEF     = 4;
   localparam int WD_TIMEOUT_US = 10;
   localparam int CLK_MHZ      = 40;
   localparam int WD_CYCLES    = WD_TIMEOUT_US * CLK_MHZ;
   localparam int WD_CNT_W     = 16;
   localparam int CNT_W        = 4;

   typedef enum logic [3:0] {
      AES_INIT = 4'b0001,
      AES_RUN  = 4'b0010,
      AES_FAIL = 4'b0100,
      AES_MASTER_RESET_JUMPER = 4'b1000
   } aes_state_t;

   typedef struct packed {
      logic master_reset_jumper;
      logic firmware_reload_jumper;
      logic motor_off_select;
   } aes_jumpers_t;

   typedef struct packed {
      logic kick;
      logic init_done;
      logic servo_enable_command;
      logic motor_off_command;
   } aes_cpu_t;

endpackage

// *** aes_supervisor.sv ***
`timescale 1ns/1ps
module aes_supervisor #(
   parameter int AXES      = aes_pkg::AXES_DEF,
   parameter int WD_CYCLES = aes_pkg::WD_CYCLES
) (
   // Clock and reset
   input  wire logic                    mclk_i,
   input  wire logic                    resetn_i,
   // Jumpers and processor
   input  wire aes_pkg::aes_jumpers_t   jumpers_i,
   input  wire logic [AXES-1:0]         stepper_select_jumper_i,
   input  wire aes_pkg::aes_cpu_t       cpu_i,
   input  wire logic [AXES-1:0]         sinus_axis_i,
   // Outputs
   output logic                         amplifier_enable_out_o,
   output logic                         error_led_o,
   output logic                         motor_enable_o,
   output logic                         erase_nvm_o,
   output logic                         firmware_reload_allow_o,
   output logic [AXES-1:0]              step_dir_mode_o,
   output logic [AXES-1:0]              dac_main_used_o,
   output logic [AXES-1:0]              dac_second_used_o,
   output logic [AXES-1:0]              axis_avail_o,
   output logic [aes_pkg::CNT_W-1:0]    std_axis_count_o
);
   import aes_pkg::*;

   // ****************************************
   // Parameter check
   // ****************************************
   if (AXES < 1 || AXES >= (1 << CNT_W) || WD_CYCLES < 1
       || WD_CYCLES >= (1 << WD_CNT_W)) begin : g_bad_params
      $error("aes_supervisor: bad parameters");
   end

   // ****************************************
   // Reset synchroniser
   // ****************************************
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ****************************************
   // Watchdog state machine
   // ****************************************
   aes_state_t            state;
   aes_state_t            next_state;
   logic [WD_CNT_W-1:0]   wd_cnt;
   logic                  kicked;
   logic                  wd_at_limit;
   logic                  wd_expired;

   assign wd_at_limit = (wd_cnt == WD_CNT_W'(WD_CYCLES - 1));
   assign wd_expired  = wd_at_limit && !cpu_i.kick;

   always_comb begin
      next_state = state;
      case (state)
         AES_MASTER_RESET_JUMPER: next_state = AES_INIT;
         AES_INIT: begin
            if (wd_expired) begin
               next_state = AES_FAIL;
            end else if (cpu_i.init_done && kicked) begin
               next_state = AES_RUN;
            end
         end
         AES_RUN: begin
            if (wd_expired) begin
               next_state = AES_FAIL;
            end
         end
         AES_FAIL: next_state = AES_FAIL;
         default:  next_state = AES_FAIL;
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         state <= AES_MASTER_RESET_JUMPER;
      end else if (state == AES_MASTER_RESET_JUMPER && !jumpers_i.master_reset_jumper) begin
         state <= AES_INIT;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         wd_cnt <= '0;
      end else if (cpu_i.kick || state == AES_FAIL || state == AES_MASTER_RESET_JUMPER) begin
         wd_cnt <= '0;
      end else if (!wd_expired) begin
         wd_cnt <= wd_cnt + 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         kicked <= 1'b0;
      end else if (cpu_i.kick && state == AES_INIT) begin
         kicked <= 1'b1;
      end
   end

   // ****************************************
   // Amplifier enable and error
   // ****************************************
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         amplifier_enable_out_o <= 1'b0;
      end else begin
         amplifier_enable_out_o <= (next_state == AES_RUN);
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         error_led_o <= 1'b0;
      end else begin
         error_led_o <= (next_state == AES_FAIL);
      end
   end

   // ****************************************
   // Master reset and upgrade
   // ****************************************
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         erase_nvm_o <= 1'b0;
      end else begin
         erase_nvm_o <= (state == AES_MASTER_RESET_JUMPER) && jumpers_i.master_reset_jumper;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         firmware_reload_allow_o <= 1'b0;
      end else begin
         firmware_reload_allow_o <= jumpers_i.firmware_reload_jumper
                                    || (state == AES_RUN);
      end
   end

   // ****************************************
   // Motor on/off
   // ****************************************
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         motor_enable_o <= 1'b0;
      end else if (state == AES_MASTER_RESET_JUMPER) begin
         motor_enable_o <= !jumpers_i.motor_off_select;
      end else if (cpu_i.motor_off_command) begin
         motor_enable_o <= 1'b0;
      end else if (cpu_i.servo_enable_command) begin
         motor_enable_o <= 1'b1;
      end
   end

   // ****************************************
   // Stepper and DAC assignment
   // ****************************************
   logic [AXES-1:0]       next_second;
   logic [AXES-1:0]       next_avail;
   logic [CNT_W-1:0]      next_count;
   logic [AXES-1:0]       taken;
   logic                  found;

   always_comb begin
      next_second = '0;
      taken       = '0;
      next_count  = CNT_W'(AXES);
      found       = 1'b0;
      for (int a = 0; a < AXES; a++) begin
         found = 1'b0;
         if (sinus_axis_i[a] && !stepper_select_jumper_i[a] && !taken[a]) begin
            for (int t = AXES - 1; t > a; t--) begin
               if (!found && !taken[t] && !sinus_axis_i[t]) begin
                  found          = 1'b1;
                  next_second[t] = 1'b1;
                  taken[t]       = 1'b1;
                  next_count     = next_count - 1'b1;
               end
            end
         end
      end
      next_avail = ~taken;
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         step_dir_mode_o   <= '0;
         dac_main_used_o   <= '0;
         dac_second_used_o <= '0;
         axis_avail_o      <= '0;
         std_axis_count_o  <= '0;
      end else begin
         step_dir_mode_o   <= stepper_select_jumper_i & next_avail;
         dac_main_used_o   <= next_avail & ~stepper_select_jumper_i;
         dac_second_used_o <= next_second;
         axis_avail_o      <= next_avail;
         std_axis_count_o  <= next_count;
      end
   end

endmodule

// *** aes_amp_model.sv ***
`timescale 1ns/1ps
// ****
// Amplifier stage
// ****
module aes_amp_model (
   input  wire logic mclk_i,
   input  wire logic enable_i,
   output logic      powered_o
);
   always_ff @(posedge mclk_i) begin
      powered_o <= enable_i;
   end
endmodule

// *** aes_supervisor_chk.sv ***
`timescale 1ns/1ps
// ****
// Supervisor checks
// ****
module aes_chk #(
   parameter int WD_CYCLES = 400
) (
   input wire logic                  mclk_i,
   input wire logic                  resetn_i,
   input wire aes_pkg::aes_jumpers_t jumpers_i,
   input wire aes_pkg::aes_cpu_t     cpu_i,
   input wire logic                  amplifier_enable_out_o,
   input wire logic                  error_led_o,
   input wire logic                  motor_enable_o,
   input wire logic                  erase_nvm_o
);
   import aes_pkg::*;
   logic [15:0] idle;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) idle <= 16'h0;
      else if (cpu_i.kick) idle <= 16'h0;
      else if (idle != 16'hffff) idle <= idle + 16'h1;
   end
   sequence tripped;
      error_led_o && !amplifier_enable_out_o;
   endsequence
   chk_fail_amp_off: assert property (error_led_o |-> !amplifier_enable_out_o)
      else $error("amp enable high while failed");
   chk_fail_sticks: assert property (error_led_o |=> tripped)
      else $error("failed state left without reset");
   chk_init_first: assert property ($rose(amplifier_enable_out_o) |-> $past(cpu_i.init_done))
      else $error("amp enable before init");
   chk_amp_drop: assert property ($fell(amplifier_enable_out_o) |-> ##[0:1] error_led_o)
      else $error("amp enable fell without trip");
   chk_kick_holds: assert property (amplifier_enable_out_o && cpu_i.kick |=> amplifier_enable_out_o)
      else $error("amp enable lost after kick");
   chk_wd_bound: assert property (int'(idle) > WD_CYCLES + 3 |-> !amplifier_enable_out_o)
      else $error("watchdog did not trip");
   chk_erase_pulse: assert property (erase_nvm_o |-> jumpers_i.master_reset_jumper ##1 !erase_nvm_o)
      else $error("bad erase pulse");
   chk_motor_off: assert property (cpu_i.motor_off_command |=> !motor_enable_o)
      else $error("motor off ignored");
   chk_servo_on: assert property (cpu_i.servo_enable_command && !cpu_i.motor_off_command |=> motor_enable_o)
      else $error("servo enable ignored");
endmodule
bind aes_supervisor aes_chk #(.WD_CYCLES(WD_CYCLES)) chk (.mclk_i(mclk_i), .resetn_i(resetn_i),
   .jumpers_i(jumpers_i), .cpu_i(cpu_i), .amplifier_enable_out_o(amplifier_enable_out_o),
   .error_led_o(error_led_o), .motor_enable_o(motor_enable_o), .erase_nvm_o(erase_nvm_o));

// *** aes_supervisor_test.sv ***
`timescale 1ns/1ps
// ****
// Supervisor bench
// ****
module aes_supervisor_test;
   import aes_pkg::*;
   localparam int WD = 20;
   logic         mclk_i = 1'b0;
   logic         resetn_i = 1'b0;
   aes_jumpers_t jumpers_i = '0;
   aes_cpu_t     cpu_i = '0;
   logic [3:0]   step_i = '0;
   logic [3:0]   sinus_i = '0;
   logic         amp, err, motor, erase, fw, powered;
   logic [3:0]   step_o, avail, cnt;
   logic [3:0]   dmain, dsec;
   int           mismatches = 0;
   int           check_count = 0;
   int           erased;
   always #12.5 mclk_i = ~mclk_i;
   aes_supervisor #(.AXES(4), .WD_CYCLES(WD)) dut (.mclk_i(mclk_i), .resetn_i(resetn_i),
      .jumpers_i(jumpers_i), .stepper_select_jumper_i(step_i), .cpu_i(cpu_i),
      .sinus_axis_i(sinus_i), .amplifier_enable_out_o(amp), .error_led_o(err),
      .motor_enable_o(motor), .erase_nvm_o(erase), .firmware_reload_allow_o(fw),
      .step_dir_mode_o(step_o), .dac_main_used_o(dmain), .dac_second_used_o(dsec),
      .axis_avail_o(avail), .std_axis_count_o(cnt));
   aes_amp_model amp_model (.mclk_i(mclk_i), .enable_i(amp), .powered_o(powered));
   task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic restart(input logic [2:0] j, input logic [3:0] s, input logic [3:0] b);
      @(negedge mclk_i);
      resetn_i = 1'b0;
      jumpers_i = aes_jumpers_t'(j);
      step_i = s;
      sinus_i = b;
      cpu_i = '0;
      repeat (16) @(negedge mclk_i);
      resetn_i = 1'b1;
      erased = 0;
      repeat (5) begin
         @(negedge mclk_i);
         erased += int'(erase);
      end
   endtask
   task automatic pulse(input logic [3:0] c);
      @(negedge mclk_i);
      cpu_i = aes_cpu_t'(cpu_i | c);
      @(negedge mclk_i);
      cpu_i = aes_cpu_t'(cpu_i & 4'h4);
   endtask
   task automatic run(input int n);
      for (int i = 0; i < n; i++) begin
         if (i % 5 == 0) pulse(4'h8);
         else @(negedge mclk_i);
      end
   endtask
   initial begin
      restart(3'h7, 4'ha, 4'h0);
      check("erase", 4'h1, erased[3:0]);
      check("motor", 4'h0, {3'h0, motor});
      check("reload", 4'h1, {3'h0, fw});
      check("stepdir", 4'ha, step_o);
      check("dacmain", 4'h5, dmain);
      check("dacsec", 4'h0, dsec);
      pulse(4'h8);
      check("amp", 4'h0, {3'h0, amp});
      pulse(4'h4);
      for (int i = 0; i < 8 && amp !== 1'b1; i++) @(negedge mclk_i);
      check("amp", 4'h1, {3'h0, amp});
      pulse(4'h2);
      check("motor", 4'h1, {3'h0, motor});
      run(60);
      check("powered", 4'h1, {3'h0, powered});
      $display("test power_up done");
      repeat (WD + 6) @(negedge mclk_i);
      check("error", 4'h1, {3'h0, err});
      check("powered", 4'h0, {3'h0, powered});
      run(20);
      check("amp", 4'h0, {3'h0, amp});
      $display("test watchdog done");
      restart(3'h0, 4'h0, 4'h1);
      check("erase", 4'h0, erased[3:0]);
      check("motor", 4'h1, {3'h0, motor});
      check("avail", 4'h7, avail);
      check("count", 4'h3, cnt);
      check("reload", 4'h0, {3'h0, fw});
      check("dacsec", 4'h8, dsec);
      check("dacmain", 4'h7, dmain);
      sinus_i = 4'h3;
      repeat (3) @(negedge mclk_i);
      check("avail", 4'h3, avail);
      check("count", 4'h2, cnt);
      check("dacsec", 4'hc, dsec);
      check("dacmain", 4'h3, dmain);
      pulse(4'h3);
      check("motor", 4'h0, {3'h0, motor});
      $display("test axes done");
      finish_test();
   end
endmodule
